// >>> shared/pns_regs.vh
`ifndef PNS_REGS_VH
`define PNS_REGS_VH

// register word addresses
`define PNS_ADDR_W          8
`define PNS_DATA_W          16
`define PNS_A_NEG_EXP       8'h06
`define PNS_A_NX_TX         8'h07
`define PNS_A_PHY_STS       8'h10
`define PNS_A_FC_CNT        8'h14
`define PNS_A_RXERR_CNT     8'h15
`define PNS_A_TENMEG        8'h18
`define PNS_A_IRQ_STS       8'h1C
`define PNS_A_IRQ_MASK      8'h1D

// next page transmit fields
`define PNS_NX_REQ_BIT      15
`define PNS_NX_RSV_BIT      14
`define PNS_NX_MS_BIT       13
`define PNS_NX_CMPL_BIT     12
`define PNS_NX_TOG_BIT      11
`define PNS_NX_CODE_HI      10
`define PNS_NX_CODE_LO      0
`define PNS_NX_CODE_W       11
`define PNS_NX_REQ_RST      1'h0
`define PNS_NX_MS_RST       1'h1
`define PNS_NX_CMPL_RST     1'h0
`define PNS_NX_TOG_RST      1'h0
`define PNS_NX_CODE_RST     11'h001

// combined status fields (15:14 reserved)
`define PNS_ST_RXERR_BIT    13
`define PNS_ST_POL_BIT      12
`define PNS_ST_FC_BIT       11
`define PNS_ST_SD_BIT       10
`define PNS_ST_LOCK_BIT     9
`define PNS_ST_PAGE_BIT     8

// negotiation expansion fields
`define PNS_EX_PDF_BIT      4
`define PNS_EX_LPNP_BIT     3
`define PNS_EX_NPABLE_BIT   2
`define PNS_EX_PAGE_BIT     1
`define PNS_EX_LPAN_BIT     0
`define PNS_EX_NPABLE_VAL   1'h1

// ten megabit status field
`define PNS_TM_POL_BIT      4

// counters
`define PNS_CNT_W           8
`define PNS_CNT_RST         8'h00
`define PNS_CNT_MAX         8'hFF

// sticky flag indices
`define PNS_F_RXERR         0
`define PNS_F_FC            1
`define PNS_F_POL           2
`define PNS_F_PAGE          3
`define PNS_F_SD_DROP       4
`define PNS_F_LOCK_DROP     5
`define PNS_F_PDF           6
`define PNS_F_IRQ0          7
`define PNS_NUM_FLAGS       13
`define PNS_NUM_IRQ         6
`define PNS_FLAG_RST        13'h0030
`define PNS_IRQ_MASK_RST    6'h00

`endif

// >>> core/pns_flag.v
`timescale 1ns/1ps
// sticky flag: set beats clear in the same cycle
module pns_flag #(
	parameter RST_VAL = 1'b0
) (
	input  wire clk,
	input  wire resetn,
	input  wire ce,
	input  wire set,
	input  wire clr,
	output reg  q
);

	always @(posedge clk)
	begin
		if (!resetn)
			q <= RST_VAL;
		else if (ce)
		begin
			if (set)
				q <= 1'b1;
			else if (clr)
				q <= 1'b0;
		end
	end

endmodule // pns_flag

// >>> core/pns_top.v
`timescale 1ns/1ps
`include "pns_regs.vh"
// How it works
// - bit 12 of next page register is read/write comply acknowledge, reset 0.
// - bit 11 is read-only toggle, inverse of previous exchanged word toggle.
// - bits 10:0 are read/write code; message code when bit 13 set.
// - code field resets to 001, the null message page.
// - status bits 15:14 reserved, writes ignored, read zero.
// - status bit 13 latches on receive error, cleared by reading 0x15.
// - status bit 12 latches on polarity inversion; cleared by ten meg read, not status read.
// - status bit 11 latches on false carrier, cleared by reading 0x14.
// - status bit 10 reports signal detect as latch-low, reset 0.
// - status bit 9 reports descrambler lock as latch-low, reset 0.
// - status bit 8 copies page received; only expansion read clears it.
// - bit 15 read/write next page request reset 0; bit 14 reads zero.
// - page received sets on received code word, cleared by expansion read.
module pns_top #(
	parameter CNT_W = `PNS_CNT_W
) (
	input  wire                      CORE_CLK,
	input  wire                      RESETN,
	input  wire                      CE,
	input  wire                      SW_RESET,
	input  wire [`PNS_ADDR_W-1:0]    ADDR,
	input  wire [`PNS_DATA_W-1:0]    WDATA,
	input  wire                      WE,
	input  wire                      RE,
	output reg  [`PNS_DATA_W-1:0]    RDATA,
	output wire                      IRQ,
	input  wire                      RX_ERROR_EVENT,
	input  wire                      FALSE_CARRIER_EVENT,
	input  wire                      POLARITY_INVERTED,
	input  wire                      SIGNAL_DETECT,
	input  wire                      DESCRAMBLER_LOCK,
	input  wire                      PAGE_RECEIVED_EVENT,
	input  wire                      RX_TOGGLE,
	input  wire                      PARALLEL_FAULT_EVENT,
	input  wire                      LP_NEXT_PAGE_ABLE,
	input  wire                      LP_NEG_ABLE,
	input  wire                      WORD_EXCHANGED,
	input  wire                      EXCHANGED_TOGGLE,
	output reg                       MORE_PAGES_REQUEST,
	output reg                       MESSAGE_PAGE_FLAG,
	output reg                       COMPLY_ACKNOWLEDGE,
	output reg                       NEXT_TOGGLE,
	output reg  [`PNS_NX_CODE_W-1:0] NEXT_CODE
);

	////////////////////////////////////////////////////////////////////////
	// decode

	// software reset acts like the pin reset on every piece of state
	wire rst_n = RESETN & ~SW_RESET;

	wire wr_nx    = WE & (ADDR == `PNS_A_NX_TX);
	wire wr_fc    = WE & (ADDR == `PNS_A_FC_CNT);
	wire wr_rxerr = WE & (ADDR == `PNS_A_RXERR_CNT);
	wire wr_mask  = WE & (ADDR == `PNS_A_IRQ_MASK);

	wire rd_exp   = RE & (ADDR == `PNS_A_NEG_EXP);
	wire rd_sts   = RE & (ADDR == `PNS_A_PHY_STS);
	wire rd_fc    = RE & (ADDR == `PNS_A_FC_CNT);
	wire rd_rxerr = RE & (ADDR == `PNS_A_RXERR_CNT);
	wire rd_tm    = RE & (ADDR == `PNS_A_TENMEG);
	wire rd_irq   = RE & (ADDR == `PNS_A_IRQ_STS);

	////////////////////////////////////////////////////////////////////////
	// next page transmit register

	always @(posedge CORE_CLK)
	begin
		if (!rst_n)
		begin
			MORE_PAGES_REQUEST <= `PNS_NX_REQ_RST;
			MESSAGE_PAGE_FLAG  <= `PNS_NX_MS_RST;
			COMPLY_ACKNOWLEDGE <= `PNS_NX_CMPL_RST;
			NEXT_CODE          <= `PNS_NX_CODE_RST;
		end
		else if (CE && wr_nx)
		begin
			MORE_PAGES_REQUEST <= WDATA[`PNS_NX_REQ_BIT];
			MESSAGE_PAGE_FLAG  <= WDATA[`PNS_NX_MS_BIT];
			COMPLY_ACKNOWLEDGE <= WDATA[`PNS_NX_CMPL_BIT];
			NEXT_CODE <= WDATA[`PNS_NX_CODE_HI:`PNS_NX_CODE_LO];
		end
	end

	// toggle is hardware owned; a software write never reaches it
	always @(posedge CORE_CLK)
	begin
		if (!rst_n)
			NEXT_TOGGLE <= `PNS_NX_TOG_RST;
		else if (CE && WORD_EXCHANGED)
			NEXT_TOGGLE <= ~EXCHANGED_TOGGLE;
	end

	////////////////////////////////////////////////////////////////////////
	// event counters, sticky at full scale, cleared by a read

	reg  [CNT_W-1:0] fc_count;
	reg  [CNT_W-1:0] rxerr_count;
	wire [CNT_W-1:0] cnt_max = {CNT_W{1'b1}};

	always @(posedge CORE_CLK)
	begin
		if (!rst_n)
		begin
			fc_count    <= {CNT_W{1'b0}};
			rxerr_count <= {CNT_W{1'b0}};
		end
		else if (CE)
		begin
			// an event in the reading cycle restarts the count at one
			if (wr_fc)
				fc_count <= WDATA[CNT_W-1:0];
			else if (rd_fc)
				fc_count <= {{(CNT_W-1){1'b0}}, FALSE_CARRIER_EVENT};
			else if (FALSE_CARRIER_EVENT && fc_count != cnt_max)
				fc_count <= fc_count + {{(CNT_W-1){1'b0}}, 1'b1};
			if (wr_rxerr)
				rxerr_count <= WDATA[CNT_W-1:0];
			else if (rd_rxerr)
				rxerr_count <= {{(CNT_W-1){1'b0}}, RX_ERROR_EVENT};
			else if (RX_ERROR_EVENT && rxerr_count != cnt_max)
				rxerr_count <= rxerr_count + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// latch-low history

	reg sd_prev;
	reg lock_prev;

	always @(posedge CORE_CLK)
	begin
		if (!rst_n)
		begin
			sd_prev   <= 1'b0;
			lock_prev <= 1'b0;
		end
		else if (CE)
		begin
			sd_prev   <= SIGNAL_DETECT;
			lock_prev <= DESCRAMBLER_LOCK;
		end
	end

	wire sd_fall   = sd_prev & ~SIGNAL_DETECT;
	wire lock_fall = lock_prev & ~DESCRAMBLER_LOCK;

	////////////////////////////////////////////////////////////////////////
	// sticky flags

	wire [`PNS_NUM_FLAGS-1:0] flag_set;
	wire [`PNS_NUM_FLAGS-1:0] flag_clr;
	wire [`PNS_NUM_FLAGS-1:0] flag;
	// a constant, so each flag instance can take its own reset bit
	localparam [`PNS_NUM_FLAGS-1:0] flag_rst = `PNS_FLAG_RST;
	wire [`PNS_NUM_IRQ-1:0]   irq_event;
	reg  [`PNS_NUM_IRQ-1:0]   irq_mask;

	assign flag_set[`PNS_F_RXERR]     = RX_ERROR_EVENT;
	assign flag_clr[`PNS_F_RXERR]     = rd_rxerr;
	assign flag_set[`PNS_F_FC]        = FALSE_CARRIER_EVENT;
	assign flag_clr[`PNS_F_FC]        = rd_fc;
	assign flag_set[`PNS_F_POL]       = POLARITY_INVERTED;
	assign flag_clr[`PNS_F_POL]       = rd_tm;
	assign flag_set[`PNS_F_PAGE]      = PAGE_RECEIVED_EVENT;
	assign flag_clr[`PNS_F_PAGE]      = rd_exp;
	// drop history resets set so both latch-low bits read 0 at start
	assign flag_set[`PNS_F_SD_DROP]   = ~SIGNAL_DETECT;
	assign flag_clr[`PNS_F_SD_DROP]   = rd_sts;
	assign flag_set[`PNS_F_LOCK_DROP] = ~DESCRAMBLER_LOCK;
	assign flag_clr[`PNS_F_LOCK_DROP] = rd_sts;
	assign flag_set[`PNS_F_PDF]       = PARALLEL_FAULT_EVENT;
	assign flag_clr[`PNS_F_PDF]       = rd_exp;

	assign irq_event = {lock_fall, sd_fall, PAGE_RECEIVED_EVENT,
		POLARITY_INVERTED & ~flag[`PNS_F_POL], FALSE_CARRIER_EVENT,
		RX_ERROR_EVENT};
	assign flag_set[`PNS_NUM_FLAGS-1:`PNS_F_IRQ0] = irq_event;
	assign flag_clr[`PNS_NUM_FLAGS-1:`PNS_F_IRQ0] = {`PNS_NUM_IRQ{rd_irq}};

	genvar gi;
	generate
		for (gi = 0; gi < `PNS_NUM_FLAGS; gi = gi + 1)
		begin : g_flag
			pns_flag #(
				.RST_VAL (flag_rst[gi])
			) u_flag (
				.clk    (CORE_CLK),
				.resetn (rst_n),
				.ce     (CE),
				.set    (flag_set[gi]),
				.clr    (flag_clr[gi]),
				.q      (flag[gi])
			);
		end
	endgenerate

	always @(posedge CORE_CLK)
	begin
		if (!rst_n)
			irq_mask <= `PNS_IRQ_MASK_RST;
		else if (CE && wr_mask)
			irq_mask <= WDATA[`PNS_NUM_IRQ-1:0];
	end

	assign IRQ = |(flag[`PNS_NUM_FLAGS-1:`PNS_F_IRQ0] & irq_mask);

	////////////////////////////////////////////////////////////////////////
	// read words

	reg [`PNS_DATA_W-1:0] nx_word;
	reg [`PNS_DATA_W-1:0] sts_word;
	reg [`PNS_DATA_W-1:0] exp_word;
	reg [`PNS_DATA_W-1:0] tm_word;
	reg [`PNS_DATA_W-1:0] rd_mux;

	always @*
	begin
		nx_word = {`PNS_DATA_W{1'b0}};
		nx_word[`PNS_NX_REQ_BIT]  = MORE_PAGES_REQUEST;
		nx_word[`PNS_NX_MS_BIT]   = MESSAGE_PAGE_FLAG;
		nx_word[`PNS_NX_CMPL_BIT] = COMPLY_ACKNOWLEDGE;
		nx_word[`PNS_NX_TOG_BIT]  = NEXT_TOGGLE;
		nx_word[`PNS_NX_CODE_HI:`PNS_NX_CODE_LO] = NEXT_CODE;

		sts_word = {`PNS_DATA_W{1'b0}};
		sts_word[`PNS_ST_RXERR_BIT] = flag[`PNS_F_RXERR];
		sts_word[`PNS_ST_POL_BIT]   = flag[`PNS_F_POL];
		sts_word[`PNS_ST_FC_BIT]    = flag[`PNS_F_FC];
		sts_word[`PNS_ST_SD_BIT]    =
			SIGNAL_DETECT & ~flag[`PNS_F_SD_DROP];
		sts_word[`PNS_ST_LOCK_BIT]  =
			DESCRAMBLER_LOCK & ~flag[`PNS_F_LOCK_DROP];
		sts_word[`PNS_ST_PAGE_BIT]  = flag[`PNS_F_PAGE];

		exp_word = {`PNS_DATA_W{1'b0}};
		exp_word[`PNS_EX_PDF_BIT]    = flag[`PNS_F_PDF];
		exp_word[`PNS_EX_LPNP_BIT]   = LP_NEXT_PAGE_ABLE;
		exp_word[`PNS_EX_NPABLE_BIT] = `PNS_EX_NPABLE_VAL;
		exp_word[`PNS_EX_PAGE_BIT]   = flag[`PNS_F_PAGE];
		exp_word[`PNS_EX_LPAN_BIT]   = LP_NEG_ABLE;

		tm_word = {`PNS_DATA_W{1'b0}};
		tm_word[`PNS_TM_POL_BIT] = flag[`PNS_F_POL];

		case (ADDR)
			`PNS_A_NEG_EXP:   rd_mux = exp_word;
			`PNS_A_NX_TX:     rd_mux = nx_word;
			`PNS_A_PHY_STS:   rd_mux = sts_word;
			`PNS_A_FC_CNT:    rd_mux = {{(`PNS_DATA_W-CNT_W){1'b0}}, fc_count};
			`PNS_A_RXERR_CNT: rd_mux = {{(`PNS_DATA_W-CNT_W){1'b0}}, rxerr_count};
			`PNS_A_TENMEG:    rd_mux = tm_word;
			`PNS_A_IRQ_STS:
				rd_mux = {{(`PNS_DATA_W-`PNS_NUM_IRQ){1'b0}},
					flag[`PNS_NUM_FLAGS-1:`PNS_F_IRQ0]};
			`PNS_A_IRQ_MASK:
				rd_mux = {{(`PNS_DATA_W-`PNS_NUM_IRQ){1'b0}}, irq_mask};
			default:          rd_mux = {`PNS_DATA_W{1'b0}};
		endcase
	end

	// data stand only in the cycle after the strobe, zero otherwise
	always @(posedge CORE_CLK)
	begin
		if (!rst_n)
			RDATA <= {`PNS_DATA_W{1'b0}};
		else if (CE)
			RDATA <= RE ? rd_mux : {`PNS_DATA_W{1'b0}};
	end

endmodule // pns_top

// >>> sim/pns_mgmt.sv
`timescale 1ns/1ps
// management master: strobes change after a rising edge, one cycle each
module pns_mgmt (
	input  wire        CORE_CLK,
	input  wire [15:0] RDATA,
	output reg  [7:0]  ADDR,
	output reg  [15:0] WDATA,
	output reg         WE,
	output reg         RE
);
	initial {ADDR, WDATA, WE, RE} = 26'h0;
	task wr(input [7:0] a, input [15:0] d);
	begin
		@(posedge CORE_CLK);
		ADDR <= a;
		WDATA <= d;
		WE <= 1'b1;
		@(posedge CORE_CLK);
		WE <= 1'b0;
	end
	endtask
	// data stands only in the cycle after the strobe, so take it mid-cycle
	task rd(input [7:0] a, output [15:0] d);
	begin
		@(posedge CORE_CLK);
		ADDR <= a;
		RE <= 1'b1;
		@(posedge CORE_CLK);
		RE <= 1'b0;
		@(negedge CORE_CLK);
		d = RDATA;
	end
	endtask
endmodule // pns_mgmt

// >>> sim/pns_props.sv
`timescale 1ns/1ps
`include "pns_regs.vh"
module pns_props #(
	parameter CNT_W = 8
) (
	input wire                      CORE_CLK,
	input wire                      RESETN,
	input wire                      CE,
	input wire                      SW_RESET,
	input wire [`PNS_ADDR_W-1:0]    ADDR,
	input wire [`PNS_DATA_W-1:0]    WDATA,
	input wire                      WE,
	input wire                      RE,
	input wire [`PNS_DATA_W-1:0]    RDATA,
	input wire                      RX_ERROR_EVENT,
	input wire                      FALSE_CARRIER_EVENT,
	input wire                      PAGE_RECEIVED_EVENT,
	input wire                      SIGNAL_DETECT,
	input wire                      WORD_EXCHANGED,
	input wire                      EXCHANGED_TOGGLE,
	input wire                      MORE_PAGES_REQUEST,
	input wire                      COMPLY_ACKNOWLEDGE,
	input wire                      NEXT_TOGGLE,
	input wire [`PNS_NX_CODE_W-1:0] NEXT_CODE
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RESETN || SW_RESET);
	sequence rd_sts; CE && RE && ADDR == 8'h10; endsequence
	sequence wr_nx; CE && WE && ADDR == 8'h07; endsequence
	// event, then a cycle without the clearing read, as a status poll would see it
	sequence rx_seen; CE && RX_ERROR_EVENT ##1 !(RE && ADDR == 8'h15); endsequence
	sequence fc_seen; CE && FALSE_CARRIER_EVENT ##1 !(RE && ADDR == 8'h14); endsequence
	sequence pg_seen; CE && PAGE_RECEIVED_EVENT ##1 !(RE && ADDR == 8'h06); endsequence
	np_reset_a: assert property (disable iff (1'b0) !RESETN |=>
		NEXT_CODE == 11'h001 && !COMPLY_ACKNOWLEDGE && !MORE_PAGES_REQUEST && !NEXT_TOGGLE)
		else $error("next page word not reset");
	ack_write_a: assert property (wr_nx |=> COMPLY_ACKNOWLEDGE == $past(WDATA[12]))
		else $error("comply bit not written");
	code_write_a: assert property (wr_nx |=> NEXT_CODE == $past(WDATA[10:0]))
		else $error("code not written");
	req_write_a: assert property (wr_nx |=> MORE_PAGES_REQUEST == $past(WDATA[15]))
		else $error("page request not written");
	tog_inv_a: assert property (CE && WORD_EXCHANGED |=> NEXT_TOGGLE != $past(EXCHANGED_TOGGLE))
		else $error("toggle not inverted");
	tog_hold_a: assert property (CE && !WORD_EXCHANGED |=> $stable(NEXT_TOGGLE))
		else $error("toggle moved");
	sts_rsv_a: assert property (rd_sts |=> RDATA[15:14] == 2'b00)
		else $error("reserved status bits set");
	rxerr_latch_a: assert property (rx_seen ##1 rd_sts |=> RDATA[13])
		else $error("rx error latch missing");
	fc_latch_a: assert property (fc_seen ##1 rd_sts |=> RDATA[11])
		else $error("false carrier latch missing");
	page_copy_a: assert property (pg_seen ##1 rd_sts |=> RDATA[8])
		else $error("page received copy missing");
	sd_low_a: assert property (CE && !SIGNAL_DETECT ##1 rd_sts |=> !RDATA[10])
		else $error("signal detect drop lost");
endmodule // pns_props
bind pns_top pns_props #(.CNT_W(CNT_W)) u_props (.CORE_CLK, .RESETN, .CE, .SW_RESET, .ADDR,
	.WDATA, .WE, .RE, .RDATA, .RX_ERROR_EVENT, .FALSE_CARRIER_EVENT, .PAGE_RECEIVED_EVENT,
	.SIGNAL_DETECT, .WORD_EXCHANGED, .EXCHANGED_TOGGLE, .MORE_PAGES_REQUEST,
	.COMPLY_ACKNOWLEDGE, .NEXT_TOGGLE, .NEXT_CODE);

// >>> sim/tb.sv
`timescale 1ns/1ps
module tb;
	reg         clk;
	reg         rstn;
	reg         swr;
	reg  [5:0]  ev;
	reg         xtog;
	reg         sd;
	reg         lk;
	reg  [1:0]  lp;
	wire [7:0]  addr;
	wire [15:0] wdata;
	wire        we;
	wire        re;
	wire [15:0] rdata;
	wire        irq;
	wire        req;
	wire        msg;
	wire        cack;
	wire        ntog;
	wire [10:0] code;
	reg  [15:0] d;
	reg  [15:0] pg;
	integer     fails;
	integer     tests_run;
	integer     i;
	pns_mgmt u_mgmt (.CORE_CLK(clk), .RDATA(rdata), .ADDR(addr), .WDATA(wdata), .WE(we),
		.RE(re));
	// ev: rx error, false carrier, polarity, page, parallel fault, word exchanged
	pns_top u_dut (.CORE_CLK(clk), .RESETN(rstn), .CE(1'b1), .SW_RESET(swr), .ADDR(addr),
		.WDATA(wdata), .WE(we), .RE(re), .RDATA(rdata), .IRQ(irq), .RX_ERROR_EVENT(ev[0]),
		.FALSE_CARRIER_EVENT(ev[1]), .POLARITY_INVERTED(ev[2]), .SIGNAL_DETECT(sd),
		.DESCRAMBLER_LOCK(lk), .PAGE_RECEIVED_EVENT(ev[3]), .RX_TOGGLE(1'b0),
		.PARALLEL_FAULT_EVENT(ev[4]), .LP_NEXT_PAGE_ABLE(lp[1]), .LP_NEG_ABLE(lp[0]),
		.WORD_EXCHANGED(ev[5]), .EXCHANGED_TOGGLE(xtog), .MORE_PAGES_REQUEST(req),
		.MESSAGE_PAGE_FLAG(msg), .COMPLY_ACKNOWLEDGE(cack), .NEXT_TOGGLE(ntog), .NEXT_CODE(code));
	////////////////////////////////////////
	task chk(input [15:0] got, input [15:0] exp);
	begin
		tests_run = tests_run + 1;
		if (got !== exp)
		begin
			fails = fails + 1;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask
	task rdc(input [7:0] a, input [15:0] exp);
	begin
		u_mgmt.rd(a, d);
		chk(d, exp);
	end
	endtask
	task pulse(input [5:0] m);
	begin
		@(posedge clk);
		ev <= m;
		@(posedge clk);
		ev <= 6'h00;
	end
	endtask
	// irq is combinational from flops: look once the edge has settled
	task chk_irq(input e);
	begin
		@(negedge clk);
		chk({15'h0, irq}, {15'h0, e});
	end
	endtask
	task tally_and_finish;
	begin
		if (fails == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	end
	endtask
	////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial
	begin
		repeat (5000) @(posedge clk);
		fails = fails + 1;
		tally_and_finish;
	end
	initial
	begin
		{rstn, swr, ev, xtog, sd, lk} = 11'h0;
		{fails, tests_run} = 64'h0;
		i = $urandom(32'h380b);
		lp = 2'($urandom);
		pg = 16'h2001;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		rdc(8'h07, pg);
		rdc(8'h10, 16'h0000);
		for (i = 1; i >= 0; i = i - 1)
		begin
			@(posedge clk);
			xtog <= i[0];
			pulse(6'h20);
			pg[11] = ~i[0];
			rdc(8'h07, pg);
		end
		// all-ones first: reserved and read-only bits must not follow the write
		for (i = 0; i < 5; i = i + 1)
		begin
			d = (i == 0) ? 16'hFFFF : 16'($urandom);
			u_mgmt.wr(8'h07, d);
			pg = (d & 16'hB7FF) | 16'h0800;
			rdc(8'h07, pg);
			chk({req, 1'b0, msg, cack, ntog, code}, pg);
		end
		u_mgmt.wr(8'h10, 16'hFFFF);
		pulse(6'h1F);
		rdc(8'h10, 16'h3900);
		rdc(8'h10, 16'h3900);
		rdc(8'h15, 16'h0001);
		rdc(8'h10, 16'h1900);
		rdc(8'h14, 16'h0001);
		rdc(8'h10, 16'h1100);
		rdc(8'h18, 16'h0010);
		rdc(8'h10, 16'h0100);
		rdc(8'h06, {11'h000, 1'b1, lp[1], 2'b11, lp[0]});
		rdc(8'h10, 16'h0000);
		@(posedge clk);
		sd <= 1'b1;
		lk <= 1'b1;
		rdc(8'h10, 16'h0000);
		rdc(8'h10, 16'h0600);
		@(posedge clk);
		sd <= 1'b0;
		@(posedge clk);
		sd <= 1'b1;
		rdc(8'h10, 16'h0200);
		rdc(8'h10, 16'h0600);
		u_mgmt.rd(8'h1C, d);
		u_mgmt.wr(8'h1D, 16'h0001);
		chk_irq(1'b0);
		pulse(6'h01);
		chk_irq(1'b1);
		u_mgmt.wr(8'h1D, 16'h0000);
		chk_irq(1'b0);
		u_mgmt.wr(8'h1D, 16'h0001);
		chk_irq(1'b1);
		rdc(8'h1C, 16'h0001);
		chk_irq(1'b0);
		u_mgmt.wr(8'h3F, 16'hFFFF);
		rdc(8'h3F, 16'h0000);
		@(posedge clk);
		swr <= 1'b1;
		@(posedge clk);
		swr <= 1'b0;
		rdc(8'h07, 16'h2001);
		tally_and_finish;
	end
endmodule // tb
